//--- src/sfl_pkg.sv
/*
 * Shared constants and types of the supervisor fault logic: register offsets,
 * timing figures and their cycle counts, state codes and the status layout.
 * Assumes a 10 MHz block clock.
 */
package sfl_pkg;
    // Block clock rate.
    localparam int SFL_CLK_HZ = 10_000_000;
    localparam int SFL_CYC_PER_MS = SFL_CLK_HZ / 1000;
    // Timing figures in milliseconds.
    localparam int SFL_WD_TIMEOUT_MS = 200;
    localparam int SFL_WD_PULSE_MS = 14;
    localparam int SFL_POR_MS = 200;
    // Counter width and the derived cycle counts.
    localparam int SFL_CNT_W = 24;
    localparam logic [23:0] SFL_WD_TIMEOUT_CYC = 24'(SFL_WD_TIMEOUT_MS * SFL_CYC_PER_MS);
    localparam logic [23:0] SFL_WD_PULSE_CYC = 24'(SFL_WD_PULSE_MS * SFL_CYC_PER_MS);
    localparam logic [23:0] SFL_POR_CYC = 24'(SFL_POR_MS * SFL_CYC_PER_MS);
    // Register byte offsets on the APB port.
    localparam logic [11:0] SFL_OFF_WD_TIMEOUT = 12'h000;
    localparam logic [11:0] SFL_OFF_WD_PULSE = 12'h004;
    localparam logic [11:0] SFL_OFF_POR_DELAY = 12'h008;
    localparam logic [11:0] SFL_OFF_STATUS = 12'h00c;
    // Number of low-side channels.
    localparam int SFL_NCH = 3;

    // Supervisor states, one-hot.
    typedef enum logic [6:0] {
        SFL_ST_SLEEP   = 7'h01,
        SFL_ST_THERMAL = 7'h02,
        SFL_ST_SUPPLY_UNDERVOLTAGE_FLAG    = 7'h04,
        SFL_ST_POR     = 7'h08,
        SFL_ST_WAIT    = 7'h10,
        SFL_ST_RUN     = 7'h20,
        SFL_ST_ALARM   = 7'h40
    } sfl_state_t;

    // Status word as read back by software.
    typedef struct packed {
        logic wd_pulse_phase;
        logic [2:0] oc_latched;
        logic [2:0] chan_on;
        logic supply_on;
        logic reset_level;
        logic [6:0] state;
    } sfl_status_t;
endpackage

//--- src/sfl_por_timer.sv
/*
 * Power-on delay counter: counts while run is high, flags done at the
 * terminal count and restarts from zero whenever run drops.
 * Assumes the single block clock and its asynchronous low reset.
 */
`timescale 1ns/100ps
module sfl_por_timer #(
    parameter int W = 24
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [W-1:0] terminal,
    output logic done
);
    logic [W-1:0] count;

    // Count up while running; done marks the terminal cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            done <= 1'b0;
        end else if (!run) begin
            count <= '0;
            done <= 1'b0;
        end else if (count + W'(1) >= terminal) begin
            done <= 1'b1;
        end else begin
            count <= count + W'(1);
        end
    end
endmodule

//--- src/sfl_channel.sv
/*
 * One low-side channel: gates the input onto the driver and keeps the
 * overcurrent latch that holds the driver off until the input rises again or the supervisor sleeps.
 * Assumes inputs synchronous to clk; enable comes from the supervisor.
 */
`timescale 1ns/100ps
module sfl_channel (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic sleep,
    input wire logic chan_in,
    input wire logic overcurrent,
    output logic out_on,
    output logic latched
);
    logic prev_in;
    logic next_latched;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Trip sets the latch and wins over the re-arm edge in the same cycle.
    always_comb begin
        next_latched = latched;
        if (overcurrent && out_on) begin
            next_latched = 1'b1;
        end else if (chan_in && !prev_in) begin
            next_latched = 1'b0;
        end else if (sleep) begin
            next_latched = 1'b0;
        end
    end

    // Latch, edge history and the driver itself.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_in <= 1'b0;
            latched <= 1'b0;
            out_on <= 1'b0;
        end else begin
            prev_in <= chan_in;
            latched <= next_latched;
            out_on <= enable && chan_in && !next_latched;
        end
    end

    a_oc_latch_off: assert property (overcurrent && out_on |=> !out_on && latched)
        else $error("overcurrent did not latch the channel off");
    a_chan_follow: assert property (enable && !latched && !(overcurrent && out_on)
        && !(chan_in && !prev_in) |=> out_on == $past(chan_in))
        else $error("enabled channel did not follow its input");
endmodule

//--- src/sfl_supervisor.sv
/*
 * Supervisor fault logic top: wake decode, fault precedence, power-on delay,
 * edge-kicked watchdog with pulse train, reset output, three gated channels
 * and an APB slave holding the timing counts and a status word.
 * Assumes all pins synchronous to clk and an APB master on the same clock.
 */
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
module sfl_supervisor import sfl_pkg::*; #(
    parameter logic [23:0] WD_TIMEOUT_CYC = SFL_WD_TIMEOUT_CYC,
    parameter logic [23:0] WD_PULSE_CYC = SFL_WD_PULSE_CYC,
    parameter logic [23:0] POR_CYC = SFL_POR_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic logic_wake_input,
    input wire logic battery_wake_input,
    input wire logic watchdog_kick_input,
    input wire logic thermal_shutdown_flag,
    input wire logic supply_undervoltage_flag,
    input wire logic [2:0] channel_input,
    input wire logic [2:0] channel_overcurrent_flag,
    output logic reset_fault_out_n,
    output logic regulated_supply_on,
    output logic [2:0] channel_output_on
);
    sfl_state_t state;
    sfl_state_t next_state;
    logic [23:0] wd_timeout;
    logic [23:0] wd_pulse;
    logic [23:0] por_delay;
    logic [23:0] wd_count;
    logic wd_down;
    logic kick_prev;
    logic kick_edge;
    logic wd_active;
    logic wd_trip;
    logic wd_pulse_end;
    logic por_done;
    logic awake;
    logic quiet;
    logic chan_enable;
    logic [2:0] chan_on;
    logic [2:0] oc_latched;
    logic [31:0] read_word;
    logic addr_ok;
    sfl_status_t status;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Wake decode and the absence of any higher fault.
    assign awake = logic_wake_input || battery_wake_input;
    assign quiet = awake && !thermal_shutdown_flag && !supply_undervoltage_flag;

    // Any kick transition counts, so a kick tied back to the reset pin
    // self-kicks on each pulse and cuts every alarm pulse of an unused watchdog short.
    assign kick_edge = watchdog_kick_input != kick_prev;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            kick_prev <= 1'b0;
        end else begin
            kick_prev <= watchdog_kick_input;
        end
    end

    // Watchdog runs only once the power-on delay is over.
    assign wd_active = (state == SFL_ST_WAIT) || (state == SFL_ST_RUN) || (state == SFL_ST_ALARM);
    assign wd_trip = wd_active && !wd_down && !kick_edge
        && (wd_count == wd_timeout - 24'h1);
    assign wd_pulse_end = wd_down && (wd_count == wd_pulse - 24'h1);

    // Charge phase counts to the timeout, discharge phase to the pulse width.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_count <= 24'h0;
            wd_down <= 1'b0;
        end else if (!wd_active || kick_edge) begin
            wd_count <= 24'h0;
            wd_down <= 1'b0;
        end else if (wd_trip) begin
            wd_count <= 24'h0;
            wd_down <= 1'b1;
        end else if (wd_pulse_end) begin
            wd_count <= 24'h0;
            wd_down <= 1'b0;
        end else begin
            wd_count <= wd_count + 24'h1;
        end
    end

    // Power-on delay counter, restarted each time the POR state is entered.
    sfl_por_timer #(
        .W(SFL_CNT_W)
    ) u_por (
        .clk(clk),
        .rst_n(rst_n),
        .run(state == SFL_ST_POR),
        .terminal(por_delay),
        .done(por_done)
    );

    // Higher conditions override lower ones regardless of the state.
    always_comb begin
        next_state = state;
        if (!awake) begin
            next_state = SFL_ST_SLEEP;
        end else if (thermal_shutdown_flag) begin
            next_state = SFL_ST_THERMAL;
        end else if (supply_undervoltage_flag) begin
            next_state = SFL_ST_SUPPLY_UNDERVOLTAGE_FLAG;
        end else begin
            case (state)
                SFL_ST_SLEEP, SFL_ST_THERMAL, SFL_ST_SUPPLY_UNDERVOLTAGE_FLAG: begin
                    next_state = SFL_ST_POR;
                end
                SFL_ST_POR: begin
                    if (por_done) begin
                        next_state = SFL_ST_WAIT;
                    end
                end
                SFL_ST_WAIT: begin
                    if (kick_edge) begin
                        next_state = SFL_ST_RUN;
                    end else if (wd_trip) begin
                        next_state = SFL_ST_ALARM;
                    end
                end
                SFL_ST_RUN: begin
                    if (wd_trip) begin
                        next_state = SFL_ST_ALARM;
                    end
                end
                SFL_ST_ALARM: begin
                    if (kick_edge) begin
                        next_state = SFL_ST_RUN;
                    end
                end
                default: begin
                    next_state = SFL_ST_SLEEP;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SFL_ST_SLEEP;
        end else begin
            state <= next_state;
        end
    end

    // Reset pin level low for held faults, pulsed in alarm; supply off only in sleep and thermal.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_fault_out_n <= 1'b0;
            regulated_supply_on <= 1'b0;
        end else begin
            regulated_supply_on <= (state != SFL_ST_SLEEP)
                && (state != SFL_ST_THERMAL);
            case (state)
                SFL_ST_WAIT, SFL_ST_RUN: reset_fault_out_n <= 1'b1;
                SFL_ST_ALARM: reset_fault_out_n <= !wd_down;
                default: reset_fault_out_n <= 1'b0;
            endcase
        end
    end

    // Channels drive only in normal run, after the first kick.
    assign chan_enable = state == SFL_ST_RUN;

    genvar ch;
    generate
        for (ch = 0; ch < SFL_NCH; ch++) begin : g_chan
            sfl_channel u_chan (
                .clk(clk),
                .rst_n(rst_n),
                .enable(chan_enable),
                .sleep(state == SFL_ST_SLEEP),
                .chan_in(channel_input[ch]),
                .overcurrent(channel_overcurrent_flag[ch]),
                .out_on(chan_on[ch]),
                .latched(oc_latched[ch])
            );
        end
    endgenerate

    assign channel_output_on = chan_on;

    // Timing registers: software may shorten or lengthen each terminal count.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_timeout <= WD_TIMEOUT_CYC;
            wd_pulse <= WD_PULSE_CYC;
            por_delay <= POR_CYC;
        end else if (psel && penable && pready && pwrite) begin
            case (paddr)
                SFL_OFF_WD_TIMEOUT: wd_timeout <= pwdata[23:0];
                SFL_OFF_WD_PULSE: wd_pulse <= pwdata[23:0];
                SFL_OFF_POR_DELAY: por_delay <= pwdata[23:0];
                default: ;
            endcase
        end
    end

    // Status word and read multiplexer.
    assign status = '{wd_pulse_phase: wd_down, oc_latched: oc_latched,
        chan_on: chan_on, supply_on: regulated_supply_on,
        reset_level: reset_fault_out_n, state: state};

    always_comb begin
        addr_ok = 1'b1;
        read_word = 32'h0;
        case (paddr)
            SFL_OFF_WD_TIMEOUT: read_word = {8'h00, wd_timeout};
            SFL_OFF_WD_PULSE: read_word = {8'h00, wd_pulse};
            SFL_OFF_POR_DELAY: read_word = {8'h00, por_delay};
            SFL_OFF_STATUS: read_word = {16'h0000, status};
            default: addr_ok = 1'b0;
        endcase
    end

    // Answer is registered in the setup cycle so the access phase has no wait.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= !addr_ok || (pwrite && paddr == SFL_OFF_STATUS);
            prdata <= pwrite ? 32'h0 : read_word;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
    end

    // Sequences used by the watchdog checks.
    sequence s_kick_in_wait;
        state == SFL_ST_WAIT && kick_edge && quiet;
    endsequence

    sequence s_trip_while_healthy;
        wd_trip && quiet && (state == SFL_ST_RUN || state == SFL_ST_WAIT);
    endsequence

    a_wake_leaves_sleep: assert property (awake |=> state != SFL_ST_SLEEP)
        else $error("awake device stayed in sleep");
    a_sleep_all_off: assert property (state == SFL_ST_SLEEP |=> !regulated_supply_on
        && !reset_fault_out_n && channel_output_on == 3'b000)
        else $error("sleep left something on");
    a_kick_restarts: assert property (wd_active && kick_edge |=> wd_count == 24'h0
        && !wd_down)
        else $error("kick edge did not restart the watchdog");
    a_trip_alarm: assert property (s_trip_while_healthy |=> state == SFL_ST_ALARM
        ##1 !reset_fault_out_n)
        else $error("timeout did not raise the alarm pulse");
    a_pulse_width: assert property (wd_down && wd_active && !kick_edge && !wd_pulse_end
        |=> wd_down)
        else $error("reset pulse ended early");
    a_alarm_pulses: assert property (state == SFL_ST_ALARM && wd_down
        |=> !reset_fault_out_n)
        else $error("alarm did not pulse the reset output");
    a_alarm_dark: assert property (state == SFL_ST_ALARM |=> channel_output_on == 3'b000)
        else $error("channel driven during watchdog alarm");
    a_wait_dark: assert property (state == SFL_ST_WAIT |=> channel_output_on == 3'b000)
        else $error("channel driven before the first kick");
    a_kick_enables: assert property (s_kick_in_wait |=> state == SFL_ST_RUN)
        else $error("first kick did not enable the channels");
    a_por_holds: assert property (state == SFL_ST_POR |=> !reset_fault_out_n)
        else $error("reset released during power-on delay");
    a_supply_undervoltage_flag_reset: assert property (awake && !thermal_shutdown_flag && supply_undervoltage_flag
        |-> ##2 !reset_fault_out_n && channel_output_on == 3'b000)
        else $error("undervoltage did not force reset");
    a_thermal_cut: assert property (awake && thermal_shutdown_flag
        |-> ##2 !regulated_supply_on && !reset_fault_out_n)
        else $error("thermal shutdown kept the supply on");

    // Steps that end one reset pulse of the alarm train.
    sequence s_pulse_done;
        state == SFL_ST_ALARM && wd_pulse_end && quiet;
    endsequence

    sequence s_release_pin;
        !wd_down ##1 reset_fault_out_n;
    endsequence

    // Pulse train release, held faults, precedence and the register write path.
    a_pulse_release: assert property (s_pulse_done |=> s_release_pin)
        else $error("reset pulse did not end after the pulse width");
    a_alarm_exit: assert property (state == SFL_ST_ALARM && kick_edge && quiet
        |=> state == SFL_ST_RUN)
        else $error("kick did not end the watchdog alarm");
    a_held_fault_low: assert property (state == SFL_ST_SUPPLY_UNDERVOLTAGE_FLAG || state == SFL_ST_THERMAL
        |=> !reset_fault_out_n)
        else $error("held fault released the reset output");
    a_run_reset_high: assert property (state == SFL_ST_RUN |=> reset_fault_out_n)
        else $error("reset output low in normal run");
    a_supply_undervoltage_flag_supply: assert property (state == SFL_ST_SUPPLY_UNDERVOLTAGE_FLAG |=> regulated_supply_on)
        else $error("undervoltage switched the supply off");
    a_por_to_wait: assert property (state == SFL_ST_POR && por_done && quiet
        |=> state == SFL_ST_WAIT)
        else $error("power-on delay did not end on time");
    a_dark_unless_run: assert property (state != SFL_ST_RUN
        |=> channel_output_on == 3'b000)
        else $error("channel driven outside normal run");
    a_sleep_first: assert property (!awake |=> state == SFL_ST_SLEEP)
        else $error("sleep did not take precedence");
    a_thermal_next: assert property (awake && thermal_shutdown_flag
        |=> state == SFL_ST_THERMAL)
        else $error("thermal shutdown did not take precedence");
    a_write_lands: assert property (psel && penable && pready && pwrite
        && paddr == SFL_OFF_POR_DELAY |=> por_delay == $past(pwdata[23:0]))
        else $error("delay register write did not land");
endmodule

//--- verification/sfl_mcu_model.sv
/*
 * Microcontroller stand-in: toggles the watchdog kick and drives the channel commands.
 * Assumes the bench clock and reset, and the supervisor's reset level as its own reset.
 */
`timescale 1ns/100ps
module sfl_mcu_model #(
    parameter int KICK_GAP = 40
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic kick_en,
    input wire logic [2:0] chan_cmd,
    input wire logic reset_fault_out_n,
    input wire logic kick_tie,
    output logic watchdog_kick_input,
    output logic [2:0] channel_input
);
    int cnt;
    logic kick_q;

    // The kick line toggles every KICK_GAP cycles while enabled and out of reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            kick_q <= 1'b0;
        end else if (kick_en && reset_fault_out_n) begin
            cnt <= (cnt == KICK_GAP - 1) ? 0 : cnt + 1;
            if (cnt == KICK_GAP - 1) begin
                kick_q <= ~kick_q;
            end
        end else begin
            cnt <= 0;
        end
    end

    // A board that leaves the watchdog unused ties the kick pin to the reset pin.
    assign watchdog_kick_input = kick_tie ? reset_fault_out_n : kick_q;

    // A processor held in reset floats its pins, so the pull-downs win.
    assign channel_input = reset_fault_out_n ? chan_cmd : 3'b000;
endmodule

//--- verification/test_supervisor_fault_logic.sv
/*
 * Self-checking bench for the supervisor: APB register access, wake and fault handling,
 * power-on delay, watchdog pulse train and channel gating.
 * Assumes the small timing counts below and a microcontroller model on the far side.
 */
`timescale 1ns/100ps
module test_supervisor_fault_logic;
    import sfl_pkg::*;
    localparam logic [23:0] TO = 24'h0000c8;
    localparam logic [23:0] PW = 24'h00000e;
    localparam logic [23:0] PD = 24'h000032;
    localparam logic [23:0] PW2 = 24'h00000a;
    typedef struct packed {
        logic [31:0] data;
        logic err;
        logic rd;
    } sfl_exp_t;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic wake_l, wake_b, kick, therm, uv, kick_en, kick_tie, reset_fault_out_n, supply_on;
    logic [2:0] cmd, chan_in, oc, channel_output_on;
    logic [3:0] fv [5];
    logic [31:0] seed = 32'h000098d6;
    sfl_exp_t expq [$];
    sfl_exp_t e;
    int mismatches = 0;
    int checks = 0;
    int n;

    sfl_supervisor #(.WD_TIMEOUT_CYC(TO), .WD_PULSE_CYC(PW), .POR_CYC(PD)) uut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .logic_wake_input(wake_l), .battery_wake_input(wake_b),
        .watchdog_kick_input(kick), .thermal_shutdown_flag(therm),
        .supply_undervoltage_flag(uv), .channel_input(chan_in),
        .channel_overcurrent_flag(oc), .reset_fault_out_n(reset_fault_out_n),
        .regulated_supply_on(supply_on), .channel_output_on(channel_output_on));

    sfl_mcu_model mcu (.clk(clk), .rst_n(rst_n), .kick_en(kick_en), .chan_cmd(cmd),
        .reset_fault_out_n(reset_fault_out_n), .kick_tie(kick_tie), .watchdog_kick_input(kick),
        .channel_input(chan_in));

    // The clock toggles every 50 ns, a period of 100 ns.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic final_report();
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks++;
        if (got !== ex) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic rng(input string nm, input int lo, input int hi, input int got);
        checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask

    // Counts cycles until the reset level reaches v; a run-out ends the test.
    task automatic wait_rst(input logic v, input int lim, output int cnt);
        cnt = 0;
        while (reset_fault_out_n !== v && cnt < lim) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= lim) begin
            mismatches++;
            final_report();
        end
    endtask

    task automatic wait_chan(input string nm);
        int k;
        k = 0;
        while (channel_output_on !== cmd && k < 100) begin
            @(negedge clk);
            k++;
        end
        chk(nm, 32'(cmd), 32'(channel_output_on));
    endtask

    // Drives one APB transfer and notes the expected answer for the monitor.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic ee);
        int k;
        expq.push_back('{data: ed, err: ee, rd: !wr});
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            mismatches++;
            final_report();
        end
    endtask

    // Power-on delay, channels held off until the first kick, then running.
    task automatic recover(input int pd);
        wait_rst(1'b1, 600, n);
        rng("por_cycles", pd, pd + 8, n);
        repeat (10) @(negedge clk);
        chk("wait_chan", 32'h0, 32'(channel_output_on));
        @(posedge clk);
        kick_en <= 1'b1;
        wait_chan("run_chan");
    endtask

    // Takes the oldest note whenever the slave completes a transfer.
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            if (expq.size() == 0) begin
                chk("apb_extra", 32'h0, 32'h1);
            end else begin
                e = expq.pop_front();
                chk("apb_err", 32'(e.err), 32'(pslverr));
                if (e.rd) begin
                    chk("apb_rdata", e.data, prdata);
                end
            end
        end
    end

    initial begin
        fv = '{4'b0000, 4'b1010, 4'b1001, 4'b1011, 4'b0010};
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {wake_l, wake_b, therm, uv, oc, cmd, kick_en, kick_tie} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge clk);
        chk("sleep_supply", 32'h0, 32'(supply_on));
        chk("sleep_reset", 32'h0, 32'(reset_fault_out_n));
        @(posedge clk);
        cmd <= 3'b111;
        wake_b <= 1'b1;
        recover(PD);
        apb(1'b0, SFL_OFF_WD_TIMEOUT, 32'h0, 32'(TO), 1'b0);
        apb(1'b0, SFL_OFF_POR_DELAY, 32'h0, 32'(PD), 1'b0);
        apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
        apb(1'b1, SFL_OFF_STATUS, 32'h0000ffff, 32'h0, 1'b1);
        apb(1'b1, SFL_OFF_WD_PULSE, 32'(PW2), 32'h0, 1'b0);
        apb(1'b0, SFL_OFF_WD_PULSE, 32'h0, 32'(PW2), 1'b0);
        // Random channel commands must appear on the drivers.
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            cmd <= 3'(xs());
            repeat (4) @(negedge clk);
            chk("rand_chan", 32'(cmd), 32'(channel_output_on));
        end
        // An overcurrent latches one channel off until its input is reapplied.
        @(posedge clk);
        cmd <= 3'b111;
        oc <= 3'b010;
        // Held two edges so the trip lands whatever the last random command left on.
        repeat (2) @(posedge clk);
        oc <= 3'b000;
        repeat (12) @(negedge clk);
        chk("oc_latch", 32'h5, 32'(channel_output_on));
        chk("oc_reset", 32'h1, 32'(reset_fault_out_n));
        @(posedge clk);
        cmd <= 3'b101;
        repeat (2) @(posedge clk);
        cmd <= 3'b111;
        wait_chan("oc_rearm");
        // Each fault combination, then recovery through the power-on delay.
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            kick_en <= 1'b0;
            {wake_l, wake_b, therm, uv} <= fv[i];
            repeat (4) @(negedge clk);
            chk("flt_supply", 32'((fv[i][3] | fv[i][2]) & !fv[i][1]), 32'(supply_on));
            chk("flt_reset", 32'h0, 32'(reset_fault_out_n));
            chk("flt_chan", 32'h0, 32'(channel_output_on));
            @(posedge clk);
            {wake_l, wake_b, therm, uv} <= 4'b0100;
            recover(PD);
        end
        // Missing kicks start the pulse train; kicks resuming end it.
        @(posedge clk);
        kick_en <= 1'b0;
        wait_rst(1'b0, 400, n);
        rng("wd_timeout", TO - 45, TO + 6, n);
        wait_rst(1'b1, 100, n);
        rng("pulse_width", PW2 - 1, PW2 + 2, n);
        chk("alarm_chan", 32'h0, 32'(channel_output_on));
        wait_rst(1'b0, 400, n);
        rng("pulse_gap", TO - 2, TO + 2, n);
        wait_rst(1'b1, 100, n);
        @(posedge clk);
        kick_en <= 1'b1;
        wait_chan("wd_resume");
        repeat (300) @(negedge clk);
        chk("wd_steady", 32'h1, 32'(reset_fault_out_n));
        // A near-zero delay written by software stands in for a defeated delay node.
        apb(1'b1, SFL_OFF_POR_DELAY, 32'h1, 32'h0, 1'b0);
        @(posedge clk);
        kick_en <= 1'b0;
        uv <= 1'b1;
        repeat (4) @(posedge clk);
        uv <= 1'b0;
        recover(1);
        // With the kick tied to the reset pin the alarm only blips and the channels return.
        @(posedge clk);
        kick_en <= 1'b0;
        kick_tie <= 1'b1;
        wait_rst(1'b0, 400, n);
        wait_rst(1'b1, 10, n);
        rng("tie_pulse", 1, 3, n);
        wait_chan("tie_chan");
        final_report();
    end
endmodule
